/* File: i2c_bus_peer.sv */
// Behavioural I2C bus peer driving SCL and SDA for start, bytes, ack slots, restart and stop.
// Assumes pulled-up lines: released SDA reads 1, SCL stands high outside frames.
`timescale 1ns/10ps
module i2c_bus_peer #(
    parameter real HALF = 62.5
) (
    // Bus lines
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    task automatic start_cond();
        sda = 1'b0;
        #(HALF);
        scl = 1'b0;
        #(HALF/2);
    endtask

    // SDA only moves while SCL is low, so no false start or stop
    task automatic send_bits(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            sda = d[i];
            #(HALF/2);
            scl = 1'b1;
            #(HALF);
            scl = 1'b0;
            #(HALF/2);
        end
    endtask

    // Ninth pulse left high so the bench can look at the ack slot
    task automatic ack_rise(input logic ack);
        sda = ~ack;
        #(HALF/2);
        scl = 1'b1;
        #(HALF/2);
    endtask

    task automatic ack_fall();
        scl = 1'b0;
        #(HALF/2);
        sda = 1'b1;
        #(HALF/2);
    endtask

    task automatic restart_cond();
        sda = 1'b1;
        #(HALF/2);
        scl = 1'b1;
        #(HALF/2);
        sda = 1'b0;
        #(HALF/2);
        scl = 1'b0;
        #(HALF/2);
    endtask

    task automatic stop_cond();
        sda = 1'b0;
        #(HALF/2);
        scl = 1'b1;
        #(HALF/2);
        sda = 1'b1;
        #(HALF);
    endtask
endmodule

/* File: i2c_diagnostic_select_pkg.sv */
// Types shared by the I2C diagnostic status block.
// Constants live in i2c_diagnostic_select_regs.svh.
package i2c_diagnostic_select_pkg;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_ADDR1,
        PH_ADDR2,
        PH_DATA
    } phase_e;

    typedef struct packed {
        logic ack_valid_flag;
        logic ack_flag;
        logic address_phase_flag;
        logic data_phase_flag;
        logic ten_bit_address_flag;
        logic restart_indicator;
        logic driven_clock_level;
        logic busy_flag;
    } diagnostic_select_status_s;

    typedef struct packed {
        logic scl;
        logic sda;
        logic scl_rise;
        logic scl_fall;
        logic start_det;
        logic stop_det;
    } line_view_s;

endpackage

/* File: i2c_diagnostic_select_regs.svh */
// Register offsets, field positions, reset values and bus constants of the I2C diagnostic status block.
// Included by bare name from the design files; definitions only.
`ifndef I2C_DIAGNOSTIC_SELECT_REGS_SVH
`define I2C_DIAGNOSTIC_SELECT_REGS_SVH

`define DIAGNOSTIC_SELECT_STATUS_OFS     12'h000
`define IRQ_STATUS_OFS      12'h004
`define IRQ_MASK_OFS        12'h008
`define CONTROL_OFS         12'h00C
`define TARGET_ADDR_OFS     12'h010

`define DIAGNOSTIC_SELECT_STATUS_RST     8'h02

`define CTRL_MASTER_BIT     0
`define CTRL_START_BIT      1

`define EV_STOP_RESTART_BIT 0
`define EV_NACK_BIT         1
`define EV_ACK_VALID_BIT    2
`define EV_COUNT            3

`define TEN_BIT_PREFIX      5'h1E
`define ACK_SLOT_CNT        4'h8
`define BYTE_END_CNT        4'h9

`endif

/* File: i2c_diagnostic_select_status.sv */
// I2C diagnostic status register with bus tracking, APB slave and event interrupt.
// Assumes APB master on CLK_SYS; SCL/SDA pins are asynchronous.
//
// How it works
// - ACK flag holds last byte's acknowledge
// - Master start with 11110 prefix sets ten-bit
// - Ten-bit flag clears once address sent
// - Restart indicator: stop gives 0, restart 1
// - Clock bit shows driven level, not bus
// - Sampled bus levels go to port register
// - Busy high while a transaction runs
// - ACK-valid set after sent byte, cleared later
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`include "i2c_diagnostic_select_regs.svh"
module i2c_diagnostic_select_status (
    // Clock and reset
    input  wire logic         CLK_SYS,
    input  wire logic         SYS_RST,
    // APB slave
    input  wire logic         PSEL,
    input  wire logic         PENABLE,
    input  wire logic         PWRITE,
    input  wire logic [11:0]  PADDR,
    input  wire logic [31:0]  PWDATA,
    output logic      [31:0]  PRDATA,
    output logic              PREADY,
    output logic              PSLVERR,
    // Bus pins and controller drive
    input  wire logic         SCL_PIN,
    input  wire logic         SDA_PIN,
    input  wire logic         SCL_DRIVE_LEVEL,
    // Sampled levels towards the port input register
    output logic              PORT_SCL_LEVEL,
    output logic              PORT_SDA_LEVEL,
    // Interrupt
    output logic              IRQ
);
    i2c_diagnostic_select_pkg::line_view_s   line;
    i2c_diagnostic_select_pkg::phase_e       phase_q;
    i2c_diagnostic_select_pkg::phase_e       phase_d;
    i2c_diagnostic_select_pkg::diagnostic_select_status_s diagnostic_select;

    logic [3:0]            bit_cnt_q;
    logic [3:0]            bit_cnt_d;
    logic [7:0]            shift_q;
    logic [7:0]            shift_d;
    logic                  ack_q;
    logic                  ack_d;
    logic                  ack_valid_q;
    logic                  ack_valid_d;
    logic                  ten_bit_q;
    logic                  ten_bit_d;
    logic                  restart_q;
    logic                  restart_d;
    logic                  busy_q;
    logic                  busy_d;
    logic                  rw_q;
    logic                  rw_d;
    logic                  drv_clk_q;
    logic                  port_scl_q;
    logic                  port_sda_q;
    logic                  master_q;
    logic                  master_d;
    logic [7:0]            target_q;
    logic [7:0]            target_d;
    logic [`EV_COUNT-1:0]  mask_q;
    logic [`EV_COUNT-1:0]  mask_d;
    logic [31:0]           prdata_q;
    logic [31:0]           prdata_d;
    logic [`EV_COUNT-1:0]  events;
    logic [`EV_COUNT-1:0]  irq_status;
    logic                  wr_en;
    logic                  start_req;
    logic                  transmitting;
    logic                  ack_slot;
    logic                  byte_end;
    logic                  stop_restart_event_flag_event;

    function automatic logic is_ten_bit(input logic [7:0] addr_byte);
        is_ten_bit = (addr_byte[7:3] == `TEN_BIT_PREFIX);
    endfunction

    function automatic logic ofs_mapped(input logic [11:0] addr);
        ofs_mapped = (addr == `DIAGNOSTIC_SELECT_STATUS_OFS) || (addr == `IRQ_STATUS_OFS) || (addr == `IRQ_MASK_OFS)
                  || (addr == `CONTROL_OFS) || (addr == `TARGET_ADDR_OFS);
    endfunction

    i2c_line_sync u_sync (
        .clk     (CLK_SYS),
        .rst     (SYS_RST),
        .scl_pin (SCL_PIN),
        .sda_pin (SDA_PIN),
        .view    (line)
    );

    // Address bytes always come from the master; data direction follows the R/W bit
    assign transmitting = (phase_q == i2c_diagnostic_select_pkg::PH_ADDR1 || phase_q == i2c_diagnostic_select_pkg::PH_ADDR2)
                        ? master_q : (master_q ^ rw_q);
    assign ack_slot     = busy_q && line.scl_rise && (bit_cnt_q == `ACK_SLOT_CNT);
    assign byte_end     = busy_q && line.scl_fall && (bit_cnt_q == `BYTE_END_CNT);
    assign stop_restart_event_flag_event   = line.stop_det || (line.start_det && busy_q);

    // APB register access, zero wait states
    assign wr_en     = PSEL && PENABLE && PWRITE;
    assign start_req = wr_en && (PADDR == `CONTROL_OFS) && PWDATA[`CTRL_START_BIT];

    always_comb begin
        master_d = master_q;
        target_d = target_q;
        mask_d   = mask_q;
        prdata_d = prdata_q;
        if (wr_en && PADDR == `CONTROL_OFS) begin
            master_d = PWDATA[`CTRL_MASTER_BIT];
        end
        if (wr_en && PADDR == `TARGET_ADDR_OFS) begin
            target_d = PWDATA[7:0];
        end
        if (wr_en && PADDR == `IRQ_MASK_OFS) begin
            mask_d = PWDATA[`EV_COUNT-1:0];
        end
        if (PSEL && !PENABLE && !PWRITE) begin
            unique case (PADDR)
                `DIAGNOSTIC_SELECT_STATUS_OFS: prdata_d = {24'h000000, diagnostic_select};
                `IRQ_STATUS_OFS:  prdata_d = {{(32-`EV_COUNT){1'b0}}, irq_status};
                `IRQ_MASK_OFS:    prdata_d = {{(32-`EV_COUNT){1'b0}}, mask_q};
                `CONTROL_OFS:     prdata_d = {31'h00000000, master_q};
                `TARGET_ADDR_OFS: prdata_d = {24'h000000, target_q};
                default:          prdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            master_q <= 1'b0;
            target_q <= 8'h00;
            mask_q   <= '0;
            prdata_q <= 32'h00000000;
        end else begin
            master_q <= master_d;
            target_q <= target_d;
            mask_q   <= mask_d;
            prdata_q <= prdata_d;
        end
    end

    assign PRDATA  = prdata_q;
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !ofs_mapped(PADDR);

    // Bus tracking from synchronised SCL/SDA
    always_comb begin
        phase_d     = phase_q;
        bit_cnt_d   = bit_cnt_q;
        shift_d     = shift_q;
        ack_d       = ack_q;
        ack_valid_d = ack_valid_q;
        ten_bit_d   = ten_bit_q;
        restart_d   = restart_q;
        busy_d      = busy_q;
        rw_d        = rw_q;
        if (line.start_det) begin
            busy_d      = 1'b1;
            phase_d     = i2c_diagnostic_select_pkg::PH_ADDR1;
            bit_cnt_d   = 4'h0;
            ack_valid_d = 1'b0;
            if (busy_q) begin
                restart_d = 1'b1;
            end
        end else if (line.stop_det) begin
            busy_d      = 1'b0;
            phase_d     = i2c_diagnostic_select_pkg::PH_IDLE;
            bit_cnt_d   = 4'h0;
            ack_valid_d = 1'b0;
            ten_bit_d   = 1'b0;
            restart_d   = 1'b0;
        end else if (busy_q && line.scl_rise) begin
            if (bit_cnt_q < `ACK_SLOT_CNT) begin
                shift_d   = {shift_q[6:0], line.sda};
                bit_cnt_d = bit_cnt_q + 4'h1;
                if (bit_cnt_q == 4'h0) begin
                    ack_valid_d = 1'b0;
                end
            end else if (ack_slot) begin
                ack_d       = ~line.sda;
                bit_cnt_d   = `BYTE_END_CNT;
                ack_valid_d = transmitting;
            end
        end else if (byte_end) begin
            bit_cnt_d = 4'h0;
            unique case (phase_q)
                i2c_diagnostic_select_pkg::PH_ADDR1: begin
                    rw_d    = shift_q[0];
                    phase_d = is_ten_bit(shift_q) ? i2c_diagnostic_select_pkg::PH_ADDR2 : i2c_diagnostic_select_pkg::PH_DATA;
                end
                i2c_diagnostic_select_pkg::PH_ADDR2: phase_d = i2c_diagnostic_select_pkg::PH_DATA;
                i2c_diagnostic_select_pkg::PH_IDLE,
                i2c_diagnostic_select_pkg::PH_DATA:  phase_d = phase_q;
            endcase
            if (phase_d == i2c_diagnostic_select_pkg::PH_DATA) begin
                ten_bit_d = 1'b0;
            end
        end
        if (start_req && master_d && is_ten_bit(target_q)) begin
            ten_bit_d = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            phase_q     <= i2c_diagnostic_select_pkg::PH_IDLE;
            bit_cnt_q   <= 4'h0;
            shift_q     <= 8'h00;
            ack_q       <= 1'b0;
            ack_valid_q <= 1'b0;
            ten_bit_q   <= 1'b0;
            restart_q   <= 1'b0;
            busy_q      <= 1'b0;
            rw_q        <= 1'b0;
        end else begin
            phase_q     <= phase_d;
            bit_cnt_q   <= bit_cnt_d;
            shift_q     <= shift_d;
            ack_q       <= ack_d;
            ack_valid_q <= ack_valid_d;
            ten_bit_q   <= ten_bit_d;
            restart_q   <= restart_d;
            busy_q      <= busy_d;
            rw_q        <= rw_d;
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            drv_clk_q  <= 1'(`DIAGNOSTIC_SELECT_STATUS_RST >> 1);
            port_scl_q <= 1'b1;
            port_sda_q <= 1'b1;
        end else begin
            drv_clk_q  <= SCL_DRIVE_LEVEL;
            port_scl_q <= line.scl;
            port_sda_q <= line.sda;
        end
    end

    assign PORT_SCL_LEVEL = port_scl_q;
    assign PORT_SDA_LEVEL = port_sda_q;

    always_comb begin
        diagnostic_select.ack_valid_flag       = ack_valid_q;
        diagnostic_select.ack_flag             = ack_q;
        diagnostic_select.address_phase_flag   = busy_q && (phase_q == i2c_diagnostic_select_pkg::PH_ADDR1 || phase_q == i2c_diagnostic_select_pkg::PH_ADDR2);
        diagnostic_select.data_phase_flag      = busy_q && (phase_q == i2c_diagnostic_select_pkg::PH_DATA);
        diagnostic_select.ten_bit_address_flag = ten_bit_q;
        diagnostic_select.restart_indicator    = restart_q;
        diagnostic_select.driven_clock_level   = drv_clk_q;
        diagnostic_select.busy_flag            = busy_q;
    end

    always_comb begin
        events                        = '0;
        events[`EV_STOP_RESTART_BIT]  = stop_restart_event_flag_event;
        events[`EV_NACK_BIT]          = ack_slot && line.sda;
        events[`EV_ACK_VALID_BIT]     = ack_valid_d && !ack_valid_q;
    end

    i2c_event_irq u_irq (
        .clk      (CLK_SYS),
        .rst      (SYS_RST),
        .events   (events),
        .clr_wr   (wr_en && PADDR == `IRQ_STATUS_OFS),
        .clr_data (PWDATA[`EV_COUNT-1:0]),
        .mask     (mask_q),
        .status   (irq_status),
        .irq      (IRQ)
    );

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    sequence s_addr_done;
        byte_end && (phase_q == i2c_diagnostic_select_pkg::PH_ADDR2 || phase_q == i2c_diagnostic_select_pkg::PH_ADDR1) && !line.start_det;
    endsequence

    property p_ack_value;
        ack_slot && !line.start_det && !line.stop_det |=> (ack_q == !$past(line.sda));
    endproperty
    a_ack_value: assert property (p_ack_value) else $error("ack flag wrong");

    property p_ten_set;
        start_req && PWDATA[`CTRL_MASTER_BIT] && is_ten_bit(target_q) |=> ten_bit_q;
    endproperty
    a_ten_set: assert property (p_ten_set) else $error("ten-bit flag not set");

    property p_ten_clr;
        s_addr_done ##0 ((phase_d == i2c_diagnostic_select_pkg::PH_DATA) && !start_req) |=> !ten_bit_q;
    endproperty
    a_ten_clr: assert property (p_ten_clr) else $error("ten-bit flag not cleared");

    property p_stop_restart;
        (line.stop_det |=> !restart_q && !busy_q) and (line.start_det && busy_q |=> restart_q);
    endproperty
    a_stop_restart: assert property (p_stop_restart) else $error("restart indicator wrong");

    property p_drv_clk;
        ##1 diagnostic_select.driven_clock_level == $past(SCL_DRIVE_LEVEL);
    endproperty
    a_drv_clk: assert property (p_drv_clk) else $error("driven clock level wrong");

    property p_port_levels;
        ##1 (PORT_SDA_LEVEL == $past(line.sda)) && (PORT_SCL_LEVEL == $past(line.scl));
    endproperty
    a_port_levels: assert property (p_port_levels) else $error("port level wrong");

    property p_busy;
        (busy_q && !line.stop_det |=> busy_q) and (line.start_det |=> busy_q);
    endproperty
    a_busy: assert property (p_busy) else $error("busy dropped early");

    property p_phase;
        (line.start_det |=> diagnostic_select.address_phase_flag && !diagnostic_select.data_phase_flag)
        and (byte_end && phase_q == i2c_diagnostic_select_pkg::PH_ADDR1 && !is_ten_bit(shift_q) |=> diagnostic_select.data_phase_flag)
        and (!(diagnostic_select.address_phase_flag && diagnostic_select.data_phase_flag));
    endproperty
    a_phase: assert property (p_phase) else $error("phase flags inconsistent");

    property p_ack_valid_flag;
        (ack_slot && transmitting && !line.start_det |=> ack_valid_q)
        and (ack_valid_q && line.stop_det |=> !ack_valid_q);
    endproperty
    a_ack_valid_flag: assert property (p_ack_valid_flag) else $error("ack valid wrong");
endmodule

/* File: i2c_event_irq.sv */
// Sticky event flags, write-one-to-clear, with a mask onto one level interrupt.
// Assumes clr_wr is a single-cycle write strobe from the register slave.
`timescale 1ns/10ps
`include "i2c_diagnostic_select_regs.svh"
module i2c_event_irq (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // Events and software access
    input  wire logic [`EV_COUNT-1:0]     events,
    input  wire logic                     clr_wr,
    input  wire logic [`EV_COUNT-1:0]     clr_data,
    input  wire logic [`EV_COUNT-1:0]     mask,
    // Results
    output logic      [`EV_COUNT-1:0]     status,
    output logic                          irq
);
    logic [`EV_COUNT-1:0] status_q;
    logic [`EV_COUNT-1:0] status_d;

    // New event beats a clear in the same cycle
    always_comb begin
        status_d = (clr_wr ? (status_q & ~clr_data) : status_q) | events;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_q <= '0;
        end else begin
            status_q <= status_d;
        end
    end

    assign status = status_q;
    assign irq    = |(status_q & mask);

    property p_set_wins;
        @(posedge clk) disable iff (rst)
        (events != '0) |=> ((status_q & $past(events)) == $past(events));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost against clear");
endmodule

/* File: i2c_line_sync.sv */
// Synchronises the SCL and SDA pins to the system clock and finds edges, start and stop.
// Assumes pins are asynchronous to clk; two flops precede all logic.
`timescale 1ns/10ps
module i2c_line_sync (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // Bus pins
    input  wire logic                     scl_pin,
    input  wire logic                     sda_pin,
    // Synchronised view
    output i2c_diagnostic_select_pkg::line_view_s      view
);
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic [2:0] scl_d;
    logic [2:0] sda_d;

    always_comb begin
        scl_d = {scl_q[1:0], scl_pin};
        sda_d = {sda_q[1:0], sda_pin};
    end

    // Idle bus is high, so reset to one to avoid a false edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
        end else begin
            scl_q <= scl_d;
            sda_q <= sda_d;
        end
    end

    always_comb begin
        view.scl       = scl_q[1];
        view.sda       = sda_q[1];
        view.scl_rise  = scl_q[1] & ~scl_q[2];
        view.scl_fall  = ~scl_q[1] & scl_q[2];
        view.start_det = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
        view.stop_det  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
    end
endmodule

/* File: test_i2c_diagnostic_select_status.sv */
// Self-checking bench for the I2C diagnostic status block over APB.
// Assumes the bus peer model drives the pins; the bench drives APB and the controller clock level.
`timescale 1ns/10ps
`include "i2c_diagnostic_select_regs.svh"
module test_i2c_diagnostic_select_status;
    localparam int LIMIT = 20000;
    logic        clk_sys;
    logic        sys_rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        scl_drive;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        scl;
    logic        sda;
    logic        port_scl;
    logic        port_sda;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cycles     = 0;

    always #4 clk_sys = ~clk_sys;

    i2c_diagnostic_select_status DUT (
        .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SCL_PIN(scl), .SDA_PIN(sda), .SCL_DRIVE_LEVEL(scl_drive),
        .PORT_SCL_LEVEL(port_scl), .PORT_SDA_LEVEL(port_sda), .IRQ(irq)
    );

    i2c_bus_peer peer (
        .scl(scl),
        .sda(sda)
    );

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Hang guard, generous against roughly 1400 expected cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            num_errors++;
            $display("ERROR at %0t: timeout seen 0x%08h expected 0x%08h", $time, cycles, LIMIT);
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen 0x%08h expected 0x%08h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Pin effects need a few cycles through the synchroniser
    task automatic diagnostic_select(input logic [31:0] exp);
        repeat (8) @(posedge clk_sys);
        apb(1'b0, `DIAGNOSTIC_SELECT_STATUS_OFS, 32'h0);
        check(rd, exp);
    endtask

    task automatic end_test(input string name);
        $display("test done: %s", name);
    endtask

    initial begin
        clk_sys = 1'b0;
        sys_rst   <= 1'b1;
        psel      <= 1'b0;
        penable   <= 1'b0;
        pwrite    <= 1'b0;
        paddr     <= 12'h000;
        pwdata    <= 32'h0;
        scl_drive <= 1'b1;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        diagnostic_select(32'h02);
        apb(1'b1, `DIAGNOSTIC_SELECT_STATUS_OFS, 32'hFF);
        diagnostic_select(32'h02);
        apb(1'b0, 12'h020, 32'h0);
        check(rd, 32'h0);
        check({31'h0, err}, 32'h1);
        end_test("register map");

        scl_drive <= 1'b0;
        diagnostic_select(32'h00);
        check({30'h0, port_scl, port_sda}, 32'h3);
        scl_drive <= 1'b1;
        diagnostic_select(32'h02);
        end_test("driven clock");

        apb(1'b1, `TARGET_ADDR_OFS, 32'hE8);
        apb(1'b1, `CONTROL_OFS, 32'h03);
        diagnostic_select(32'h02);
        apb(1'b0, `CONTROL_OFS, 32'h0);
        check(rd, 32'h01);
        apb(1'b1, `TARGET_ADDR_OFS, 32'hF0);
        apb(1'b1, `CONTROL_OFS, 32'h03);
        diagnostic_select(32'h0A);
        peer.start_cond();
        peer.send_bits(8'hF0);
        diagnostic_select(32'h2B);
        peer.ack_rise(1'b1);
        diagnostic_select(32'hEB);
        check({31'h0, port_sda}, 32'h0);
        peer.ack_fall();
        check({31'h0, port_scl}, 32'h0);
        peer.send_bits(8'h12);
        diagnostic_select(32'h6B);
        peer.ack_rise(1'b1);
        peer.ack_fall();
        peer.send_bits(8'h55);
        diagnostic_select(32'h53);
        peer.ack_rise(1'b0);
        diagnostic_select(32'h93);
        peer.ack_fall();
        end_test("ten-bit master write");

        apb(1'b0, `IRQ_STATUS_OFS, 32'h0);
        check(rd, 32'h06);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, `IRQ_MASK_OFS, 32'h02);
        repeat (2) @(posedge clk_sys);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, `IRQ_STATUS_OFS, 32'h02);
        apb(1'b0, `IRQ_STATUS_OFS, 32'h0);
        check(rd, 32'h04);
        check({31'h0, irq}, 32'h0);
        end_test("interrupt");

        peer.restart_cond();
        diagnostic_select(32'h27);
        apb(1'b0, `IRQ_STATUS_OFS, 32'h0);
        check(rd, 32'h05);
        check({31'h0, irq}, 32'h0);
        peer.stop_cond();
        diagnostic_select(32'h02);
        end_test("restart and stop");

        apb(1'b1, `CONTROL_OFS, 32'h00);
        peer.start_cond();
        peer.send_bits(8'hA1);
        peer.ack_rise(1'b1);
        diagnostic_select(32'h63);
        peer.ack_fall();
        peer.send_bits(8'h3C);
        peer.ack_rise(1'b1);
        diagnostic_select(32'hD3);
        peer.ack_fall();
        peer.stop_cond();
        diagnostic_select(32'h42);
        end_test("slave read");

        // Master receiver: address sent, data received
        apb(1'b1, `CONTROL_OFS, 32'h01);
        peer.start_cond();
        peer.send_bits(8'hA1);
        peer.ack_rise(1'b1);
        diagnostic_select(32'hE3);
        peer.ack_fall();
        peer.send_bits(8'h3C);
        peer.ack_rise(1'b0);
        diagnostic_select(32'h13);
        end_test("master read");

        // Reset in mid-transfer returns to the idle view
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        diagnostic_select(32'h02);
        apb(1'b0, `IRQ_STATUS_OFS, 32'h0);
        check(rd, 32'h0);
        peer.ack_fall();
        peer.stop_cond();
        diagnostic_select(32'h02);
        end_test("reset");
        print_verdict();
    end
endmodule
